// ---- rtl/sdcr_receiver.sv ----
// spi mode 0 command receiver with frame buffer, luminance and self-test
// Functional notes
// - clock idles low, mode 0 link
// - sample data on rising clock edge
// - select falls starts, rises aborts access
// - reset restores defaults, blanks all pixels
// - codes 01h, 02h, 03h select writes
// - 80h then bytes fill whole frame
// - left to right, top down, msb leftmost
// - 40h, first row, last row, pixels
// - 20h, row number, row pixels
// - 11h turns every pixel off
// - 12h turns every pixel on
// - 13h inverts displayed image
// - 81h to 84h set frame rate
// - self-test alternates checker and all-on
// - strap high means self-test mode
module sdcr_receiver #(
   parameter longint unsigned TEST_HOLD = sdcr_pkg::TEST_HOLD_CYC  // cycles per test pattern
) (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // spi pins and strap, asynchronous
   input  wire logic       ss_n,
   input  wire logic       sclk,
   input  wire logic       mosi,
   input  wire logic       test_strap,
   // panel scan port, same clock
   input  wire logic [7:0] scan_row,
   input  wire logic [5:0] scan_col,
   output logic      [7:0] scan_data_q,
   // panel settings and status
   output logic      [1:0] lum_sel_q,
   output logic            test_mode_q,
   output logic            busy_q
);
   // row to byte address, used by the writer and the scanner
   function automatic logic [13:0] row_base(input logic [7:0] r);
      logic [13:0] w;
      w = {6'h00, r};
      return (w << 5) + (w << 3);
   endfunction

   // synchronised pins
   sdcr_pkg::sdcr_pins_type pin_a;                  // raw pins
   sdcr_pkg::sdcr_pins_type pin_s;                  // after two flops
   assign pin_a = '{ss_n: ss_n, sclk: sclk, mosi: mosi, test_strap: test_strap};

   sdcr_sync u_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin_a   (pin_a),
      .pin_s   (pin_s)
   );

   // protocol state
   sdcr_pkg::sdcr_state_type state_q, state_d;      // byte routing state
   logic        sclk_prev_q, sclk_prev_d;          // last clock level
   logic        ss_prev_q, ss_prev_d;              // last select level
   logic [2:0]  bit_cnt_q, bit_cnt_d;              // bits of current byte
   logic [6:0]  shift_q, shift_d;                  // bits gathered so far
   logic [13:0] addr_q, addr_d;                    // next pixel byte address
   logic [13:0] limit_q, limit_d;                  // end of write window
   logic [7:0]  first_q, first_d;                  // first row of block
   logic        single_q, single_d;                // single row command
   logic [13:0] sweep_q, sweep_d;                  // clear/fill address
   logic        busy_d;                            // sweep running
   logic [7:0]  fill_q, fill_d;                    // sweep byte value
   logic        inv_q, inv_d;                      // image inverted
   logic [1:0]  lum_q, lum_d;                      // commanded frame rate

   // decoded link events
   logic       bit_rise;                           // rising clock inside access
   logic       ss_rise;                            // end of access
   logic       byte_done;                          // eighth bit sampled
   logic [7:0] rx_byte;                            // completed byte
   logic       wr_en;                              // frame buffer write
   logic [13:0] wr_addr;                           // write address
   logic [7:0] wr_data;                            // write data

   assign bit_rise  = pin_s.sclk & ~sclk_prev_q & ~pin_s.ss_n;
   assign ss_rise   = pin_s.ss_n & ~ss_prev_q;
   assign byte_done = bit_rise & (bit_cnt_q == 3'h7);
   assign rx_byte   = {shift_q, pin_s.mosi};

   // next values of the protocol and command state
   always_comb begin
      state_d     = state_q;
      sclk_prev_d = pin_s.sclk;
      ss_prev_d   = pin_s.ss_n;
      bit_cnt_d   = bit_cnt_q;
      shift_d     = shift_q;
      addr_d      = addr_q;
      limit_d     = limit_q;
      first_d     = first_q;
      single_d    = single_q;
      sweep_d     = sweep_q;
      busy_d      = busy_q;
      fill_d      = fill_q;
      inv_d       = inv_q;
      lum_d       = lum_q;
      wr_en       = 1'b0;
      wr_addr     = addr_q;
      wr_data     = rx_byte;
      if (busy_q) begin
         // sweep owns the buffer; the link is held idle meanwhile
         wr_en     = 1'b1;
         wr_addr   = sweep_q;
         wr_data   = fill_q;
         sweep_d   = sweep_q + 14'h0001;
         state_d   = sdcr_pkg::ST_CMD;
         bit_cnt_d = 3'h0;
         if (sweep_q == sdcr_pkg::FB_END - 14'h0001) begin
            busy_d = 1'b0;
         end
      end else if (ss_rise || pin_s.ss_n) begin
         // select high: drop any partial access
         state_d   = sdcr_pkg::ST_CMD;
         bit_cnt_d = 3'h0;
      end else if (bit_rise) begin
         // shift in msb first
         bit_cnt_d = bit_cnt_q + 3'h1;
         shift_d   = rx_byte[6:0];
         if (byte_done) begin
            case (state_q)
               sdcr_pkg::ST_CMD: begin
                  // first byte of access is the command
                  state_d = sdcr_pkg::ST_IGNORE;
                  case (rx_byte)
                     sdcr_pkg::CMD_FULL_A, sdcr_pkg::CMD_FULL_B: begin
                        state_d = sdcr_pkg::ST_DATA;
                        addr_d  = 14'h0000;
                        limit_d = sdcr_pkg::FB_END;
                     end
                     sdcr_pkg::CMD_BLOCK_A, sdcr_pkg::CMD_BLOCK_B: begin
                        state_d  = sdcr_pkg::ST_ROW_FIRST;
                        single_d = 1'b0;
                     end
                     sdcr_pkg::CMD_ROW_A, sdcr_pkg::CMD_ROW_B: begin
                        state_d  = sdcr_pkg::ST_ROW_FIRST;
                        single_d = 1'b1;
                     end
                     sdcr_pkg::CMD_CLEAR: begin
                        busy_d  = 1'b1;
                        sweep_d = 14'h0000;
                        fill_d  = sdcr_pkg::PIX_OFF;
                        inv_d   = 1'b0;
                     end
                     sdcr_pkg::CMD_FILL: begin
                        busy_d  = 1'b1;
                        sweep_d = 14'h0000;
                        fill_d  = sdcr_pkg::PIX_ON;
                        inv_d   = 1'b0;
                     end
                     sdcr_pkg::CMD_INVERT: inv_d = ~inv_q;
                     sdcr_pkg::CMD_LUM_100: lum_d = sdcr_pkg::LUM_100;
                     sdcr_pkg::CMD_LUM_75:  lum_d = sdcr_pkg::LUM_75;
                     sdcr_pkg::CMD_LUM_50:  lum_d = sdcr_pkg::LUM_50;
                     sdcr_pkg::CMD_LUM_30:  lum_d = sdcr_pkg::LUM_30;
                     default: state_d = sdcr_pkg::ST_IGNORE;     // unknown code
                  endcase
               end
               sdcr_pkg::ST_ROW_FIRST: begin
                  // row number; single row ends its own window
                  first_d = rx_byte;
                  addr_d  = row_base(rx_byte);
                  if (single_q) begin
                     state_d = sdcr_pkg::ST_DATA;
                     limit_d = row_base(rx_byte) + 14'h0028;
                  end else begin
                     state_d = sdcr_pkg::ST_ROW_LAST;
                  end
               end
               sdcr_pkg::ST_ROW_LAST: begin
                  // window ends after the last row
                  state_d = sdcr_pkg::ST_DATA;
                  limit_d = row_base(rx_byte) + 14'h0028;
               end
               sdcr_pkg::ST_DATA: begin
                  // store inside window and frame, drop the rest
                  if ((addr_q < limit_q) && (addr_q < sdcr_pkg::FB_END)) begin
                     wr_en  = 1'b1;
                     addr_d = addr_q + 14'h0001;
                  end
               end
               sdcr_pkg::ST_IGNORE: state_d = sdcr_pkg::ST_IGNORE;
               default: state_d = sdcr_pkg::ST_IGNORE;
            endcase
         end
      end
   end

   // protocol registers; reset starts the blanking sweep
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q     <= sdcr_pkg::ST_CMD;
         sclk_prev_q <= 1'b0;
         ss_prev_q   <= 1'b1;
         bit_cnt_q   <= 3'h0;
         shift_q     <= 7'h00;
         addr_q      <= 14'h0000;
         limit_q     <= 14'h0000;
         first_q     <= 8'h00;
         single_q    <= 1'b0;
         sweep_q     <= 14'h0000;
         busy_q      <= 1'b1;
         fill_q      <= sdcr_pkg::PIX_OFF;
         inv_q       <= 1'b0;
         lum_q       <= sdcr_pkg::LUM_100;
      end else begin
         state_q     <= state_d;
         sclk_prev_q <= sclk_prev_d;
         ss_prev_q   <= ss_prev_d;
         bit_cnt_q   <= bit_cnt_d;
         shift_q     <= shift_d;
         addr_q      <= addr_d;
         limit_q     <= limit_d;
         first_q     <= first_d;
         single_q    <= single_d;
         sweep_q     <= sweep_d;
         busy_q      <= busy_d;
         fill_q      <= fill_d;
         inv_q       <= inv_d;
         lum_q       <= lum_d;
      end
   end

   // self-test state
   logic        pattern_q, pattern_d;              // 1 all-on, 0 checkerboard
   logic [31:0] hold_q, hold_d;                    // cycles shown so far
   logic        test_d;                            // strap seen high
   logic [1:0]  lum_sel_d;                         // frame rate out

   // pattern alternation while the strap is high
   always_comb begin
      test_d    = pin_s.test_strap;
      pattern_d = pattern_q;
      hold_d    = hold_q + 32'h0000_0001;
      if (!test_mode_q) begin
         pattern_d = 1'b0;
         hold_d    = 32'h0000_0000;
      end else if (hold_q == 32'(TEST_HOLD - 64'd1)) begin
         pattern_d = ~pattern_q;
         hold_d    = 32'h0000_0000;
      end
      lum_sel_d = test_mode_q ? sdcr_pkg::LUM_100 : lum_q;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         test_mode_q <= 1'b0;
         pattern_q   <= 1'b0;
         hold_q      <= 32'h0000_0000;
         lum_sel_q   <= sdcr_pkg::LUM_100;
      end else begin
         test_mode_q <= test_d;
         pattern_q   <= pattern_d;
         hold_q      <= hold_d;
         lum_sel_q   <= lum_sel_d;
      end
   end

   // frame buffer, written by link or sweep, read by the scanner
   logic [7:0]  fb_mem [sdcr_pkg::FB_BYTES];       // one bit per pixel
   logic [13:0] rd_addr;                           // scan byte address
   logic [7:0]  check_byte;                        // checkerboard byte
   assign rd_addr    = row_base(scan_row) + {8'h00, scan_col};
   assign check_byte = scan_row[0] ? sdcr_pkg::CHECK_ODD : sdcr_pkg::CHECK_EVN;

   always_ff @(posedge sys_clk) begin
      if (wr_en) begin
         fb_mem[wr_addr] <= wr_data;
      end
      if (rst) begin
         scan_data_q <= sdcr_pkg::PIX_OFF;
      end else if (test_mode_q) begin
         scan_data_q <= pattern_q ? sdcr_pkg::PIX_ON : check_byte;
      end else begin
         scan_data_q <= fb_mem[rd_addr] ^ {8{inv_q}};
      end
   end

   // checks on the design's own behaviour
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence seq_cmd(logic [7:0] c);
      byte_done && !busy_q && (state_q == sdcr_pkg::ST_CMD) && (rx_byte == c);
   endsequence

   chk_sample_shift: assert property (bit_rise && !busy_q && !byte_done |=>
      (shift_q == $past(rx_byte[6:0])) && (bit_cnt_q == $past(bit_cnt_q) + 3'h1))
      else $error("bit not shifted on rising clock");
   chk_ss_abort: assert property (ss_rise |=> (state_q == sdcr_pkg::ST_CMD) && (bit_cnt_q == 3'h0))
      else $error("access not dropped on select rise");
   chk_full_start: assert property (seq_cmd(sdcr_pkg::CMD_FULL_B) or seq_cmd(sdcr_pkg::CMD_FULL_A) |=>
      (state_q == sdcr_pkg::ST_DATA) && (addr_q == 14'h0000) && (limit_q == sdcr_pkg::FB_END))
      else $error("full frame write not armed");
   chk_block_seq: assert property (seq_cmd(sdcr_pkg::CMD_BLOCK_B) |=>
      (state_q == sdcr_pkg::ST_ROW_FIRST) && !single_q)
      else $error("block write not awaiting rows");
   chk_row_window: assert property (byte_done && !busy_q && state_q == sdcr_pkg::ST_ROW_FIRST && single_q |=>
      (state_q == sdcr_pkg::ST_DATA) && (limit_q == addr_q + 14'h0028))
      else $error("single row window wrong");
   chk_clear_sweep: assert property (seq_cmd(sdcr_pkg::CMD_CLEAR) |=> busy_q && (fill_q == sdcr_pkg::PIX_OFF)
      ##1 busy_q && (sweep_q == 14'h0001))
      else $error("clear did not start blank sweep");
   chk_fill_sweep: assert property (seq_cmd(sdcr_pkg::CMD_FILL) |=> busy_q && (fill_q == sdcr_pkg::PIX_ON))
      else $error("fill did not start lit sweep");
   chk_invert_flag: assert property (seq_cmd(sdcr_pkg::CMD_INVERT) |=> (inv_q != $past(inv_q)))
      else $error("invert flag not toggled");
   chk_lum_set: assert property (seq_cmd(sdcr_pkg::CMD_LUM_30) ##0 !test_mode_q ##1 !test_mode_q |=>
      lum_sel_q == sdcr_pkg::LUM_30)
      else $error("luminance not applied");
   chk_test_lum: assert property (pin_s.test_strap |-> ##2 (lum_sel_q == sdcr_pkg::LUM_100) || !test_mode_q)
      else $error("self-test not at maximum rate");
   chk_test_turn: assert property (test_mode_q && hold_q == 32'(TEST_HOLD - 64'd1) ##1 test_mode_q |->
      pattern_q != $past(pattern_q))
      else $error("self-test pattern did not alternate");
endmodule // sdcr_receiver

// ---- pkg/sdcr_pkg.sv ----
// shared constants and types of the spi display command receiver
package sdcr_pkg;
   // frame geometry
   localparam int unsigned ROWS      = 240;         // display rows
   localparam int unsigned ROW_BYTES = 40;          // bytes per row, 320 columns
   localparam int unsigned FB_BYTES  = 9600;        // whole frame buffer
   localparam int unsigned AW        = 14;          // frame buffer address width
   localparam logic [13:0] FB_END    = 14'h2580;    // FB_BYTES as an address
   localparam logic [7:0]  ROW_LIMIT = 8'hF0;       // ROWS as a row number

   // command codes, both printed forms of each write
   localparam logic [7:0] CMD_FULL_A  = 8'h01;      // complete frame write
   localparam logic [7:0] CMD_FULL_B  = 8'h80;
   localparam logic [7:0] CMD_BLOCK_A = 8'h02;      // consecutive rows write
   localparam logic [7:0] CMD_BLOCK_B = 8'h40;
   localparam logic [7:0] CMD_ROW_A   = 8'h03;      // single row write
   localparam logic [7:0] CMD_ROW_B   = 8'h20;
   localparam logic [7:0] CMD_CLEAR   = 8'h11;      // all pixels off
   localparam logic [7:0] CMD_FILL    = 8'h12;      // all pixels on
   localparam logic [7:0] CMD_INVERT  = 8'h13;      // invert image
   localparam logic [7:0] CMD_LUM_100 = 8'h81;      // luminance commands
   localparam logic [7:0] CMD_LUM_75  = 8'h82;
   localparam logic [7:0] CMD_LUM_50  = 8'h83;
   localparam logic [7:0] CMD_LUM_30  = 8'h84;

   // frame rate selections driven out
   localparam logic [1:0] LUM_100 = 2'h0;           // maximum frame rate
   localparam logic [1:0] LUM_75  = 2'h1;
   localparam logic [1:0] LUM_50  = 2'h2;
   localparam logic [1:0] LUM_30  = 2'h3;

   // pixel patterns
   localparam logic [7:0] PIX_OFF   = 8'h00;        // blank byte
   localparam logic [7:0] PIX_ON    = 8'hFF;        // lit byte
   localparam logic [7:0] CHECK_EVN = 8'hAA;        // checkerboard, even rows
   localparam logic [7:0] CHECK_ODD = 8'h55;        // checkerboard, odd rows

   // self-test timing
   localparam longint unsigned CLK_HZ      = 64'd50000000;  // sys_clk rate
   localparam longint unsigned TEST_HOLD_S = 64'd30;        // seconds per pattern
   localparam longint unsigned TEST_HOLD_CYC = TEST_HOLD_S * CLK_HZ;

   // synchroniser reset: select idle high, clock low, strap high
   localparam logic [3:0] PIN_IDLE = 4'h9;

   // pins entering from outside the clock domain
   typedef struct packed {
      logic ss_n;                                   // slave select, low active
      logic sclk;                                   // serial clock
      logic mosi;                                   // serial data in
      logic test_strap;                             // self-test strap
   } sdcr_pins_type;

   // protocol states
   typedef enum logic [2:0] {
      ST_CMD,                                       // awaiting command byte
      ST_ROW_FIRST,                                 // awaiting first row number
      ST_ROW_LAST,                                  // awaiting last row number
      ST_DATA,                                      // pixel bytes
      ST_IGNORE                                     // drop bytes to end of access
   } sdcr_state_type;
endpackage

// ---- rtl/sdcr_sync.sv ----
// two flip-flop synchroniser for the asynchronous pins
module sdcr_sync (
   // clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   // pins in, synchronised out
   input  wire sdcr_pkg::sdcr_pins_type pin_a,
   output sdcr_pkg::sdcr_pins_type      pin_s
);
   sdcr_pkg::sdcr_pins_type meta_q;                 // first stage, read only by second

   // plain two-stage pipe, both stages reset to pin idle levels
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_q <= sdcr_pkg::PIN_IDLE;
         pin_s  <= sdcr_pkg::PIN_IDLE;
      end else begin
         meta_q <= pin_a;
         pin_s  <= meta_q;
      end
   end
endmodule // sdcr_sync

// ---- tb/sdcr_spi_master.sv ----
// spi mode 0 master model driving the display link
module sdcr_spi_master (
   // clock
   input  wire logic sys_clk,
   // link pins
   output logic      ss_n,
   output logic      sclk,
   output logic      mosi
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle link: deselected, clock low
   initial begin
      ss_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b1;
   end

   // one bit: data set while clock low, taken at the rise
   task automatic put_bit(input logic b);
      mosi = b;
      repeat (4) @(negedge sys_clk);
      sclk = 1'b1;
      repeat (4) @(negedge sys_clk);
      sclk = 1'b0;
   endtask

   // whole access: bytes msb first, then an optional partial byte of ones
   task automatic xfer(input logic [7:0] q[$], input int tail_n = 0);
      @(negedge sys_clk);
      ss_n = 1'b0;
      repeat (4) @(negedge sys_clk);         // select to clock setup
      foreach (q[i])
         for (int k = 7; k >= 0; k--)
            put_bit(q[i][k]);
      for (int k = 0; k < tail_n; k++)
         put_bit(1'b1);
      repeat (4) @(negedge sys_clk);         // clock to select hold
      ss_n = 1'b1;
      mosi = ~mosi;                          // released line holds no value
      repeat (8) @(negedge sys_clk);         // deselect gap
   endtask
endmodule // sdcr_spi_master

// ---- tb/tb_top.sv ----
// self-checking bench of the spi display command receiver
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   // design ports
   logic       sys_clk;
   logic       rst;
   logic       ss_n;
   logic       sclk;
   logic       mosi;
   logic       test_strap;
   logic [7:0] scan_row;
   logic [5:0] scan_col;
   logic [7:0] scan_data_q;
   logic [1:0] lum_sel_q;
   logic       test_mode_q;
   logic       busy_q;
   // bookkeeping
   int         bad_count;
   int         checked;

   // 50 MHz clock
   initial sys_clk = 1'b0;
   always #10 sys_clk = ~sys_clk;

   // design with a short self-test pattern hold
   sdcr_receiver #(.TEST_HOLD(64)) u_sdcr_receiver (
      .sys_clk(sys_clk), .rst(rst), .ss_n(ss_n), .sclk(sclk), .mosi(mosi), .test_strap(test_strap),
      .scan_row(scan_row), .scan_col(scan_col), .scan_data_q(scan_data_q), .lum_sel_q(lum_sel_q),
      .test_mode_q(test_mode_q), .busy_q(busy_q));

   // far-side master
   sdcr_spi_master u_sdcr_spi_master (.sys_clk(sys_clk), .ss_n(ss_n), .sclk(sclk), .mosi(mosi));

   // compare and count
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // read one byte through the scan port, answer one cycle later
   task automatic pix(input logic [7:0] r, input logic [5:0] c, input logic [7:0] exp);
      @(negedge sys_clk);
      scan_row = r;
      scan_col = c;
      @(negedge sys_clk);
      check($sformatf("pixel byte %0d/%0d", r, c), scan_data_q, exp);
   endtask

   // bounded wait for a sweep to finish
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy_q !== 1'b0 && n < 10000) begin
         @(negedge sys_clk);
         n++;
      end
      check("busy", {7'h0, busy_q}, 8'h00);
   endtask

   // reset state and blank buffer
   task automatic t_reset();
      check("busy at reset", {7'h0, busy_q}, 8'h01);
      check("lum at reset", {6'h0, lum_sel_q}, 8'h00);
      wait_idle();
      pix(8'h00, 6'h00, 8'h00);
      pix(8'hEF, 6'h27, 8'h00);
      check("test mode", {7'h0, test_mode_q}, 8'h00);
      $display("test reset done");
   endtask

   // full-frame writes, both codes, from row 0 column 0
   task automatic t_full();
      u_sdcr_spi_master.xfer('{8'h01, 8'hA1, 8'hB2});
      pix(8'h00, 6'h00, 8'hA1);
      pix(8'h00, 6'h01, 8'hB2);
      u_sdcr_spi_master.xfer('{8'h80, 8'hC3});
      pix(8'h00, 6'h00, 8'hC3);
      pix(8'h00, 6'h01, 8'hB2);
      $display("test full done");
   endtask

   // single-row and block writes, both codes each
   task automatic t_rows();
      logic [7:0] q[$];
      u_sdcr_spi_master.xfer('{8'h20, 8'h05, 8'h96, 8'h0F});
      u_sdcr_spi_master.xfer('{8'h03, 8'h06, 8'hE7});
      pix(8'h05, 6'h00, 8'h96);
      pix(8'h05, 6'h01, 8'h0F);
      pix(8'h06, 6'h00, 8'hE7);
      q = '{8'h40, 8'h0A, 8'h0B};
      for (int i = 0; i < 41; i++)
         q.push_back(8'h10 + i[7:0]);
      u_sdcr_spi_master.xfer(q);
      u_sdcr_spi_master.xfer('{8'h02, 8'h0C, 8'h0C, 8'h5A});
      pix(8'h0A, 6'h00, 8'h10);
      pix(8'h0A, 6'h27, 8'h37);
      pix(8'h0B, 6'h00, 8'h38);
      pix(8'h0C, 6'h00, 8'h5A);
      $display("test rows done");
   endtask

   // deselect in mid-byte drops the partial byte; unknown code and overrun dropped
   task automatic t_abort();
      logic [7:0] q[$];
      u_sdcr_spi_master.xfer('{8'h03, 8'h07}, 4);
      pix(8'h07, 6'h00, 8'h00);
      u_sdcr_spi_master.xfer('{8'h03, 8'h07, 8'h81});
      pix(8'h07, 6'h00, 8'h81);
      u_sdcr_spi_master.xfer('{8'h55, 8'h03, 8'h07, 8'hEE});
      pix(8'h07, 6'h00, 8'h81);
      q = '{8'h20, 8'h08};
      for (int i = 0; i < 41; i++)
         q.push_back(8'hC0 + i[7:0]);
      u_sdcr_spi_master.xfer(q);
      pix(8'h08, 6'h27, 8'hE7);
      pix(8'h09, 6'h00, 8'h00);
      $display("test abort done");
   endtask

   // invert twice, then the four luminance codes
   task automatic t_inv_lum();
      logic [7:0] code [4] = '{8'h81, 8'h82, 8'h83, 8'h84};
      u_sdcr_spi_master.xfer('{8'h13, 8'h00});
      pix(8'h05, 6'h00, 8'h69);
      u_sdcr_spi_master.xfer('{8'h13});
      pix(8'h05, 6'h00, 8'h96);
      foreach (code[i]) begin
         u_sdcr_spi_master.xfer('{code[i]});
         check("lum", {6'h0, lum_sel_q}, i[7:0]);
      end
      $display("test invert and luminance done");
   endtask

   // strap high: both patterns at full rate, buffer kept
   task automatic t_selftest();
      bit sa;
      bit so;
      bit sd;
      {sa, so, sd} = 3'h0;
      @(negedge sys_clk);
      test_strap = 1'b1;
      repeat (6) @(negedge sys_clk);
      check("test mode on", {7'h0, test_mode_q}, 8'h01);
      check("lum in test", {6'h0, lum_sel_q}, 8'h00);
      for (int i = 0; i < 60; i++) begin
         @(negedge sys_clk);
         scan_row = {7'h0, i[0]};
         scan_col = 6'h03;
         @(negedge sys_clk);
         sa |= (i[0] == 0 && scan_data_q === 8'hAA);
         so |= (scan_data_q === 8'hFF);
         sd |= (i[0] == 1 && scan_data_q === 8'h55);
      end
      check("patterns seen", {5'h0, sa, so, sd}, 8'h07);
      test_strap = 1'b0;
      repeat (6) @(negedge sys_clk);
      check("test mode off", {7'h0, test_mode_q}, 8'h00);
      pix(8'h05, 6'h00, 8'h96);
      $display("test self-test done");
   endtask

   // reset in mid-run restores defaults and blanks the buffer
   task automatic t_reset_again();
      check("lum before reset", {6'h0, lum_sel_q}, 8'h03);
      @(negedge sys_clk);
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      check("busy after reset", {7'h0, busy_q}, 8'h01);
      check("lum after reset", {6'h0, lum_sel_q}, 8'h00);
      wait_idle();
      pix(8'h05, 6'h00, 8'h00);
      $display("test second reset done");
   endtask

   // fill then clear, whole buffer swept
   task automatic t_fill_clear();
      u_sdcr_spi_master.xfer('{8'h12});
      check("busy after fill", {7'h0, busy_q}, 8'h01);
      wait_idle();
      pix(8'h05, 6'h00, 8'hFF);
      pix(8'hEF, 6'h27, 8'hFF);
      u_sdcr_spi_master.xfer('{8'h11});
      wait_idle();
      pix(8'h00, 6'h00, 8'h00);
      pix(8'h78, 6'h14, 8'h00);
      $display("test fill and clear done");
   endtask

   // counts, verdict, end of run
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // main sequence
   initial begin
      rst = 1'b1;
      test_strap = 1'b0;
      scan_row = 8'h00;
      scan_col = 6'h00;
      bad_count = 0;
      checked = 0;
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      t_reset();
      t_full();
      t_rows();
      t_abort();
      t_inv_lum();
      t_selftest();
      t_reset_again();
      t_fill_clear();
      tally_and_finish();
   end

   // watchdog, about twice the expected run
   initial begin
      #2000000;
      bad_count++;
      tally_and_finish();
   end
endmodule // tb_top
